// ---- logic/snp_cfg.svh ----
// constants for the serial-to-network packetizer
`ifndef SNP_CFG_SVH
`define SNP_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define SNP_OFF_CTRL    8'h00
`define SNP_OFF_PACK    8'h04
`define SNP_OFF_ID      8'h08
`define SNP_OFF_WEB     8'h0c
`define SNP_OFF_RESTART 8'h10
`define SNP_OFF_SERIAL  8'h14
`define SNP_OFF_STATUS  8'h18
`define SNP_OFF_TXDATA  8'h1c
`define SNP_OFF_NAME0   8'h20
`define SNP_OFF_NAME1   8'h24
`define SNP_OFF_NAME2   8'h28
`define SNP_OFF_NAME3   8'h2c

// ****************************************
// field positions
// ****************************************
`define SNP_CTRL_FLOW   0
`define SNP_CTRL_PREBUF 1
`define SNP_CTRL_SYNC   2
`define SNP_CTRL_IDT    4
`define SNP_PACK_LEN    16
`define SNP_SER_DB      16
`define SNP_SER_PAR     18
`define SNP_SER_STOP    21
`define SNP_STAT_OVF    4
`define SNP_STAT_LEN    16

// ****************************************
// reset values and limits
// ****************************************
`define SNP_RST_ID      16'h0001
`define SNP_RST_WEB     16'h0050
`define SNP_RST_IDT     2'h0
`define SNP_RST_DIV     16'h087a
`define SNP_RST_DB      2'h3
`define SNP_MAX_LEN     11'h5b4
`define SNP_RESTART_MIN 16'h003c
`define SNP_AUTO_CHARS  24'h000004
`define SNP_RTS_MARGIN  16
`define SNP_NAME_MAX    15

// ****************************************
// timing
// ****************************************
`define SNP_CLK_NS      4
`define SNP_MS_NS       1000000
`define SNP_MS_CYCLES   (`SNP_MS_NS / `SNP_CLK_NS)
`define SNP_SEC_MS      10'h3e8

`endif

// ---- logic/snp_pkg.sv ----
// types and shared arithmetic of the packetizer
`default_nettype none
package snp_pkg;
  typedef enum logic [3:0] {
    SND_IDLE = 4'b0001,
    SND_CONN = 4'b0010,
    SND_HDR  = 4'b0100,
    SND_BODY = 4'b1000
  } snp_snd_type;

  typedef enum logic [2:0] {
    PAR_NONE  = 3'h0,
    PAR_ODD   = 3'h1,
    PAR_EVEN  = 3'h2,
    PAR_MARK  = 3'h3,
    PAR_SPACE = 3'h4
  } snp_par_type;

  // start + data + parity + stop bits of one character
  function automatic logic [3:0] snp_char_bits(input logic [1:0] dbits, input logic [2:0] par,
                                               input logic stop2);
    return 4'h7 + {2'h0, dbits} + {3'h0, par != 3'h0} + {3'h0, stop2};
  endfunction : snp_char_bits
endpackage : snp_pkg
`default_nettype wire

// ---- logic/snp_uart_if.sv ----
// serial settings and byte strobes between core and uart halves
`timescale 1ns/1ps
`default_nettype none
interface snp_uart_if;
  logic [15:0] div;
  logic [1:0]  dbits;
  logic [2:0]  par;
  logic        stop2;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        tx_start;
  logic [7:0]  tx_data;
  logic        tx_busy;
  logic        cts_ok;
  modport rx (input div, dbits, par, stop2, output rx_valid, rx_data);
  modport tx (input div, dbits, par, stop2, tx_start, tx_data, cts_ok, output tx_busy);
endinterface : snp_uart_if
`default_nettype wire

// ---- logic/snp_uart_rx.sv ----
// serial receiver with pin synchroniser
`timescale 1ns/1ps
`default_nettype none
module snp_uart_rx (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic rxd,
  snp_uart_if.rx   u
);
  logic        s1, s2, s3, lvl, busy;
  logic [15:0] cnt;
  logic [3:0]  idx, dn, stop_idx;
  logic [7:0]  sh;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      lvl <= 1'b1;
    end else begin
      s1 <= rxd;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        lvl <= s3;
      end
    end
  end

  assign dn       = 4'h5 + {2'h0, u.dbits};
  assign stop_idx = dn + {3'h0, u.par != 3'h0} + 4'h1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      cnt <= 16'h0;
      idx <= 4'h0;
      sh <= 8'h0;
      u.rx_valid <= 1'b0;
      u.rx_data <= 8'h0;
    end else begin
      u.rx_valid <= 1'b0;
      if (!busy) begin
        if (!lvl) begin
          busy <= 1'b1;
          cnt <= u.div >> 1;
          idx <= 4'h0;
        end
      end else if (cnt != 16'h0) begin
        cnt <= cnt - 16'h1;
      end else begin
        cnt <= u.div - 16'h1;
        idx <= idx + 4'h1;
        // glitch shorter than half a bit is no start
        if (idx == 4'h0 && lvl) begin
          busy <= 1'b0;
        end else if (idx != 4'h0 && idx <= dn) begin
          sh <= {lvl, sh[7:1]};
        end else if (idx == stop_idx) begin
          busy <= 1'b0;
          u.rx_valid <= 1'b1;
          u.rx_data <= sh >> (4'h8 - dn);
        end
      end
    end
  end
endmodule : snp_uart_rx
`default_nettype wire

// ---- logic/snp_uart_tx.sv ----
// serial transmitter, one character per start
`timescale 1ns/1ps
`default_nettype none
module snp_uart_tx (
  input wire logic  hclk,
  input wire logic  hresetn,
  snp_uart_if.tx    u,
  output var logic  txd
);
  logic [11:0] frame, sh;
  logic [3:0]  n, left;
  logic [7:0]  m;
  logic [15:0] cnt;
  logic        pbit;

  always_comb begin
    n = 4'h5 + {2'h0, u.dbits};
    m = 8'hff >> (4'h8 - n);
    unique case (u.par)
      snp_pkg::PAR_ODD:  pbit = ~^(u.tx_data & m);
      snp_pkg::PAR_EVEN: pbit = ^(u.tx_data & m);
      snp_pkg::PAR_SPACE: pbit = 1'b0;
      default:           pbit = 1'b1;
    endcase
    frame = 12'hffe;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < n) begin
        frame[i + 1] = u.tx_data[i];
      end
    end
    if (u.par != 3'h0) begin
      frame[n + 4'h1] = pbit;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      u.tx_busy <= 1'b0;
      txd <= 1'b1;
      sh <= 12'hfff;
      left <= 4'h0;
      cnt <= 16'h0;
    end else if (!u.tx_busy) begin
      txd <= 1'b1;
      if (u.tx_start && u.cts_ok) begin
        u.tx_busy <= 1'b1;
        sh <= frame;
        txd <= frame[0];
        left <= snp_pkg::snp_char_bits(u.dbits, u.par, u.stop2);
        cnt <= u.div - 16'h1;
      end
    end else if (cnt != 16'h0) begin
      cnt <= cnt - 16'h1;
    end else if (left == 4'h1) begin
      u.tx_busy <= 1'b0;
      txd <= 1'b1;
    end else begin
      left <= left - 4'h1;
      sh <= {1'b1, sh[11:1]};
      txd <= sh[1];
      cnt <= u.div - 16'h1;
    end
  end
endmodule : snp_uart_tx
`default_nettype wire

// ---- logic/snp_packetizer.sv ----
// serial-to-network packetizer with ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "snp_cfg.svh"
module snp_packetizer #(
  parameter int unsigned DEPTH     = 2048,
  parameter int unsigned MS_CYCLES = `SNP_MS_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic [31:0] hrdata,
  output var  logic        hresp,
  input  wire logic        rxd,
  output wire logic        txd,
  output var  logic        rts_n,
  input  wire logic        cts_n,
  input  wire logic        net_connected,
  input  wire logic        net_is_client,
  output var  logic        net_valid,
  output var  logic [7:0]  net_data,
  output var  logic        net_last,
  input  wire logic        net_ready,
  input  wire logic        net_cfg_valid,
  input  wire logic [21:0] net_cfg_word,
  output var  logic        restart_req
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 1460 || (1 << AW) != DEPTH || MS_CYCLES < 2) begin : g_chk
    $error("snp_packetizer: DEPTH must be a power of two of at least 1460, MS_CYCLES at least 2");
  end

  // ****************************************
  // registers
  // ****************************************
  logic        flow_en, prebuf_en, sync_en;
  logic [1:0]  id_type;
  logic [7:0]  pack_time;
  logic [10:0] pack_len;
  logic [15:0] mod_id, web_port, restart_s;
  logic [31:0] name_w [0:3];
  logic        tx_pend, ovf;
  logic [7:0]  tx_byte;

  logic        ph_wr;
  logic [7:0]  ph_addr;
  logic        sel;
  logic [31:0] next_rdata;

  snp_uart_if  u ();

  // ****************************************
  // ahb-lite slave, zero wait states
  // ****************************************
  assign sel = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr <= 1'b0;
      ph_addr <= 8'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
    end else begin
      ph_wr <= sel && hwrite;
      ph_addr <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      // read data captured in the address phase so hrdata leaves a flop
      hrdata <= (sel && !hwrite) ? next_rdata : 32'h0;
    end
  end

  logic [10:0] cur_len;
  logic        cts_lvl;

  always_comb begin
    next_rdata = 32'h0;
    unique case (haddr[7:0])
      `SNP_OFF_CTRL:    next_rdata = {26'h0, id_type, 1'b0, sync_en, prebuf_en, flow_en};
      `SNP_OFF_PACK:    next_rdata = {5'h0, pack_len, 8'h0, pack_time};
      `SNP_OFF_ID:      next_rdata = {16'h0, mod_id};
      `SNP_OFF_WEB:     next_rdata = {16'h0, web_port};
      `SNP_OFF_RESTART: next_rdata = {16'h0, restart_s};
      `SNP_OFF_SERIAL:  next_rdata = {10'h0, u.stop2, u.par, u.dbits, u.div};
      `SNP_OFF_STATUS:  next_rdata = {5'h0, cur_len, 11'h0, ovf, tx_pend | u.tx_busy, cts_lvl, rts_n,
                                      net_connected};
      `SNP_OFF_NAME0:   next_rdata = name_w[0];
      `SNP_OFF_NAME1:   next_rdata = name_w[1];
      `SNP_OFF_NAME2:   next_rdata = name_w[2];
      `SNP_OFF_NAME3:   next_rdata = name_w[3];
      default:          next_rdata = 32'h0;
    endcase
  end

  // control and framing settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flow_en <= 1'b0;
      prebuf_en <= 1'b0;
      sync_en <= 1'b1;
      id_type <= `SNP_RST_IDT;
      pack_time <= 8'h0;
      pack_len <= 11'h0;
      mod_id <= `SNP_RST_ID;
      web_port <= `SNP_RST_WEB;
      restart_s <= 16'h0;
    end else if (ph_wr) begin
      unique case (ph_addr)
        `SNP_OFF_CTRL: begin
          flow_en <= hwdata[`SNP_CTRL_FLOW];
          prebuf_en <= hwdata[`SNP_CTRL_PREBUF];
          sync_en <= hwdata[`SNP_CTRL_SYNC];
          id_type <= hwdata[`SNP_CTRL_IDT +: 2];
        end
        `SNP_OFF_PACK: begin
          pack_time <= hwdata[7:0];
          // lengths above the limit are clipped, never wrapped
          pack_len <= (hwdata[`SNP_PACK_LEN +: 16] > 16'(`SNP_MAX_LEN)) ? `SNP_MAX_LEN
                                                                      : hwdata[`SNP_PACK_LEN +: 11];
        end
        `SNP_OFF_ID: begin
          if (hwdata[15:0] != 16'h0) begin
            mod_id <= hwdata[15:0];
          end
        end
        `SNP_OFF_WEB:     web_port <= hwdata[15:0];
        `SNP_OFF_RESTART: restart_s <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // serial settings, also reachable from the network
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      u.div <= `SNP_RST_DIV;
      u.dbits <= `SNP_RST_DB;
      u.par <= 3'h0;
      u.stop2 <= 1'b0;
    end else if (ph_wr && ph_addr == `SNP_OFF_SERIAL && hwdata[15:0] > 16'h1) begin
      u.div <= hwdata[15:0];
      u.dbits <= hwdata[`SNP_SER_DB +: 2];
      u.par <= hwdata[`SNP_SER_PAR +: 3];
      u.stop2 <= hwdata[`SNP_SER_STOP];
    end else if (net_cfg_valid && sync_en && net_cfg_word[15:0] > 16'h1) begin
      u.div <= net_cfg_word[15:0];
      u.dbits <= net_cfg_word[`SNP_SER_DB +: 2];
      u.par <= net_cfg_word[`SNP_SER_PAR +: 3];
      u.stop2 <= net_cfg_word[`SNP_SER_STOP];
    end
  end

  // device name; last byte kept zero so at most fifteen characters stand
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 4; i++) begin
        name_w[i] <= 32'h0;
      end
    end else if (ph_wr && ph_addr >= `SNP_OFF_NAME0 && ph_addr <= `SNP_OFF_NAME3) begin
      if (ph_addr == `SNP_OFF_NAME3) begin
        name_w[3] <= {8'h0, hwdata[23:0]};
      end else begin
        name_w[ph_addr[3:2]] <= hwdata;
      end
    end
  end

  // ****************************************
  // serial transmit and handshake pins
  // ****************************************
  logic c1, c2, c3;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c1 <= 1'b1;
      c2 <= 1'b1;
      c3 <= 1'b1;
      cts_lvl <= 1'b1;
    end else begin
      c1 <= cts_n;
      c2 <= c1;
      c3 <= c2;
      if (c2 == c3) begin
        cts_lvl <= c3;
      end
    end
  end

  assign u.cts_ok   = !flow_en || !cts_lvl;
  assign u.tx_start = tx_pend;
  assign u.tx_data  = tx_byte;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_pend <= 1'b0;
      tx_byte <= 8'h0;
    end else if (ph_wr && ph_addr == `SNP_OFF_TXDATA && !tx_pend) begin
      tx_pend <= 1'b1;
      tx_byte <= hwdata[7:0];
    end else if (tx_pend && !u.tx_busy && u.cts_ok) begin
      tx_pend <= 1'b0;
    end
  end

  snp_uart_rx i_rx (
    .hclk    (hclk),
    .hresetn (hresetn),
    .rxd     (rxd),
    .u       (u.rx)
  );

  snp_uart_tx i_tx (
    .hclk    (hclk),
    .hresetn (hresetn),
    .u       (u.tx),
    .txd     (txd)
  );

  // ****************************************
  // millisecond and second ticks
  // ****************************************
  logic [31:0] ms_cnt;
  logic [9:0]  sec_cnt;
  logic        ms_tick, sec_tick;
  logic [15:0] idle_sec;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt <= 32'h0;
      ms_tick <= 1'b0;
      sec_cnt <= 10'h0;
      sec_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_cnt == 32'(MS_CYCLES - 1));
      ms_cnt <= (ms_cnt == 32'(MS_CYCLES - 1)) ? 32'h0 : ms_cnt + 32'h1;
      sec_tick <= ms_tick && (sec_cnt == `SNP_SEC_MS - 10'h1);
      if (ms_tick) begin
        sec_cnt <= (sec_cnt == `SNP_SEC_MS - 10'h1) ? 10'h0 : sec_cnt + 10'h1;
      end
    end
  end

  // restart watchdog on serial receive silence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_sec <= 16'h0;
      restart_req <= 1'b0;
    end else begin
      restart_req <= 1'b0;
      if (u.rx_valid) begin
        idle_sec <= 16'h0;
      end else if (restart_s > `SNP_RESTART_MIN && idle_sec >= restart_s) begin
        restart_req <= 1'b1;
        idle_sec <= 16'h0;
      end else if (sec_tick && idle_sec != 16'hffff) begin
        idle_sec <= idle_sec + 16'h1;
      end
    end
  end

  // ****************************************
  // frame store and closing
  // ****************************************
  logic [7:0]  fbuf [0:DEPTH-1];
  logic [AW:0] wr_ptr, rd_ptr, com_ptr, end_ptr, used;
  logic        full, accept, auto_mode, close_len, close_idle;
  logic [10:0] len_lim;
  logic [23:0] idle_cnt, gap;

  assign used      = wr_ptr - rd_ptr;
  assign full      = used == (AW + 1)'(DEPTH);
  assign accept    = u.rx_valid && (net_connected || prebuf_en) && !full;
  assign auto_mode = pack_time == 8'h0 && pack_len == 11'h0;
  assign len_lim   = auto_mode ? `SNP_MAX_LEN : pack_len;
  assign gap       = `SNP_AUTO_CHARS * {20'h0, snp_pkg::snp_char_bits(u.dbits, u.par, u.stop2)}
                     * {8'h0, u.div};
  assign close_len = accept && len_lim != 11'h0 && cur_len + 11'h1 >= len_lim;
  assign close_idle = cur_len != 11'h0 && !u.rx_valid && (auto_mode ? idle_cnt >= gap
                      : (pack_time != 8'h0 && idle_cnt >= {16'h0, pack_time}));

  always_ff @(posedge hclk) begin
    if (accept) begin
      fbuf[wr_ptr[AW-1:0]] <= u.rx_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= '0;
      com_ptr <= '0;
      cur_len <= 11'h0;
      idle_cnt <= 24'h0;
    end else begin
      if (accept) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (u.rx_valid) begin
        idle_cnt <= 24'h0;
      end else if ((auto_mode || ms_tick) && idle_cnt != 24'hffffff) begin
        idle_cnt <= idle_cnt + 24'h1;
      end
      if (close_len) begin
        com_ptr <= wr_ptr + 1'b1;
        cur_len <= 11'h0;
      end else if (close_idle) begin
        com_ptr <= wr_ptr;
        cur_len <= 11'h0;
      end else if (accept) begin
        cur_len <= cur_len + 11'h1;
      end
    end
  end

  // overflow is sticky; a new overflow beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf <= 1'b0;
    end else if (u.rx_valid && (net_connected || prebuf_en) && full) begin
      ovf <= 1'b1;
    end else if (ph_wr && ph_addr == `SNP_OFF_STATUS && hwdata[`SNP_STAT_OVF]) begin
      ovf <= 1'b0;
    end
  end

  // host held off while the store is nearly full
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rts_n <= 1'b0;
    end else begin
      rts_n <= flow_en && (used > (AW + 1)'(DEPTH - `SNP_RTS_MARGIN));
    end
  end

  // ****************************************
  // network sender
  // ****************************************
  snp_pkg::snp_snd_type snd;
  logic [1:0] hb;
  logic       conn_q, conn_pend, adv;
  logic [7:0] hdr_b;

  assign adv = !net_valid || net_ready;

  always_comb begin
    unique case (hb)
      2'h0: hdr_b = mod_id[15:8];
      2'h1: hdr_b = mod_id[7:0];
      2'h2: hdr_b = ~mod_id[15:8];
      default: hdr_b = ~mod_id[7:0];
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conn_q <= 1'b0;
      conn_pend <= 1'b0;
    end else begin
      conn_q <= net_connected;
      if (net_connected && !conn_q && net_is_client && id_type[0]) begin
        conn_pend <= 1'b1;
      end else if (!net_connected || (snd == snp_pkg::SND_IDLE && adv)) begin
        conn_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      snd <= snp_pkg::SND_IDLE;
      rd_ptr <= '0;
      end_ptr <= '0;
      hb <= 2'h0;
      net_valid <= 1'b0;
      net_data <= 8'h0;
      net_last <= 1'b0;
    end else if (!net_connected) begin
      snd <= snp_pkg::SND_IDLE;
      net_valid <= 1'b0;
      net_last <= 1'b0;
    end else if (adv) begin
      unique case (snd)
        snp_pkg::SND_IDLE: begin
          net_valid <= 1'b0;
          net_last <= 1'b0;
          hb <= 2'h0;
          if (conn_pend) begin
            snd <= snp_pkg::SND_CONN;
          end else if (com_ptr != rd_ptr) begin
            end_ptr <= com_ptr;
            snd <= id_type[1] ? snp_pkg::SND_HDR : snp_pkg::SND_BODY;
          end
        end
        snp_pkg::SND_CONN, snp_pkg::SND_HDR: begin
          net_valid <= 1'b1;
          net_data <= hdr_b;
          net_last <= snd == snp_pkg::SND_CONN && hb == 2'h3;
          hb <= hb + 2'h1;
          if (hb == 2'h3) begin
            snd <= (snd == snp_pkg::SND_CONN) ? snp_pkg::SND_IDLE : snp_pkg::SND_BODY;
          end
        end
        snp_pkg::SND_BODY: begin
          if (rd_ptr != end_ptr) begin
            net_valid <= 1'b1;
            net_data <= fbuf[rd_ptr[AW-1:0]];
            net_last <= (rd_ptr + 1'b1) == end_ptr;
            rd_ptr <= rd_ptr + 1'b1;
          end else begin
            net_valid <= 1'b0;
            net_last <= 1'b0;
            snd <= snp_pkg::SND_IDLE;
          end
        end
      endcase
    end
  end
endmodule : snp_packetizer
`default_nettype wire

// ---- test/snp_monitor.sv ----
// port assertions for the packetizer
`timescale 1ns/1ps
`default_nettype none
module snp_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        rts_n,
  input wire logic        net_connected,
  input wire logic        net_valid,
  input wire logic [7:0]  net_data,
  input wire logic        net_last,
  input wire logic        net_ready,
  input wire logic        restart_req
);
  logic rd_dp;
  logic wr_ctrl;
  logic flow;
  // shadow of flow enable, rebuilt from bus writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_dp <= 1'b0;
      wr_ctrl <= 1'b0;
      flow <= 1'b0;
    end else begin
      rd_dp <= hsel && hready && htrans[1] && !hwrite;
      wr_ctrl <= hsel && hready && htrans[1] && hwrite && haddr == 32'h0;
      if (wr_ctrl) flow <= hwdata[0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
  chk_ready_high: assert property (hreadyout) else $error("wait state seen");
  chk_rdata_idle: assert property (!rd_dp |-> hrdata == 32'h0) else $error("hrdata outside read");
  chk_net_hold: assert property (net_valid && !net_ready && net_connected |=> net_valid && $stable(net_data))
    else $error("net byte not held");
  chk_drop_stop: assert property (!net_connected |=> !net_valid) else $error("send while down");
  chk_last_valid: assert property (net_last |-> net_valid) else $error("stray last");
  chk_restart_pulse: assert property (restart_req |=> !restart_req) else $error("long restart");
  // one cycle of grace after a change of flow setting
  chk_rts_flow: assert property (!flow && !$past(flow) |-> !rts_n) else $error("rts with flow off");
endmodule : snp_monitor
bind snp_packetizer snp_monitor mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .hrdata, .hresp, .rts_n, .net_connected, .net_valid, .net_data, .net_last, .net_ready, .restart_req);
`default_nettype wire

// ---- test/snp_host.sv ----
// host-side serial sender model
`timescale 1ns/1ps
`default_nettype none
module snp_host #(
  parameter int DIV = 16
) (
  input  wire logic hclk,
  input  wire logic rts_n,
  input  wire logic txd,
  output var  logic rxd,
  output var  logic cts_n
);
  initial begin
    rxd = 1'b1;
    cts_n = 1'b0;
  end
  task automatic snd(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    while (rts_n !== 1'b0) @(posedge hclk);
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (DIV) @(posedge hclk);
    end
  endtask : snd
  task automatic set_cts(input logic v);
    cts_n <= v;
  endtask : set_cts
  // mid-bit sampling of the device transmitter, 8N1 only
  task automatic rcv(output logic [7:0] b);
    do @(posedge hclk); while (txd !== 1'b0);
    repeat (DIV / 2) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge hclk);
      b[i] = txd;
    end
  endtask : rcv
endmodule : snp_host
`default_nettype wire

// ---- test/tb_serial_to_network_packetizer.sv ----
// self-checking bench for the packetizer
`timescale 1ns/1ps
`default_nettype none
module tb_serial_to_network_packetizer;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        net_connected = 1'b0, net_is_client = 1'b0, net_ready = 1'b0, net_cfg_valid = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic [21:0] net_cfg_word = 22'h0;
  logic        hreadyout, hresp, rxd, txd, rts_n, cts_n, net_valid, net_last, restart_req;
  logic [7:0]  net_data, b;
  int          num_errors = 0, compares = 0, cyc = 0;
  always #2 hclk = ~hclk;
  snp_packetizer #(.MS_CYCLES(50)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .rxd, .txd, .rts_n, .cts_n, .net_connected, .net_is_client,
    .net_valid, .net_data, .net_last, .net_ready, .net_cfg_valid, .net_cfg_word, .restart_req);
  snp_host #(.DIV(16)) host (.hclk, .rts_n, .txd, .rxd, .cts_n);
  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // a hang costs a mismatch and ends the run
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic chk(input logic ok);
    compares++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: value mismatch", $time);
    end
  endtask : chk
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  // far side stalls one cycle on every byte
  task automatic net_exp(input logic [7:0] d, input logic l);
    do @(posedge hclk); while (net_valid !== 1'b1);
    net_ready <= 1'b1;
    @(posedge hclk);
    net_ready <= 1'b0;
    chk(net_data === d && net_last === l);
  endtask : net_exp
  task automatic t_reset();
    bus(8'h00, 1'b0, 32'h0); chk(q === 32'h4);
    bus(8'h0c, 1'b0, 32'h0); chk(q === 32'h50);
    bus(8'h10, 1'b0, 32'h0); chk(q === 32'h0);
    bus(8'h14, 1'b0, 32'h0); chk(q === 32'h0003087a);
    bus(8'h08, 1'b1, 32'h0);
    bus(8'h08, 1'b0, 32'h0); chk(q === 32'h1);
    bus(8'h40, 1'b0, 32'h0); chk(q === 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_drop();
    bus(8'h14, 1'b1, 32'h00030010);
    host.snd(8'h11);
    repeat (8) @(posedge hclk);
    bus(8'h18, 1'b0, 32'h0); chk(q[26:16] === 11'h0);
    $display("t_drop done");
  endtask : t_drop
  task automatic t_prebuf();
    bus(8'h00, 1'b1, 32'h26);
    bus(8'h04, 1'b1, 32'h00020000);
    host.snd(8'ha5);
    host.snd(8'h3c);
    repeat (8) @(posedge hclk);
    net_connected <= 1'b1;
    net_exp(8'h00, 1'b0);
    net_exp(8'h01, 1'b0);
    net_exp(8'hff, 1'b0);
    net_exp(8'hfe, 1'b0);
    net_exp(8'ha5, 1'b0);
    net_exp(8'h3c, 1'b1);
    $display("t_prebuf done");
  endtask : t_prebuf
  task automatic t_idle();
    net_connected <= 1'b0;
    bus(8'h00, 1'b1, 32'h14);
    bus(8'h04, 1'b1, 32'h2);
    net_is_client <= 1'b1;
    net_connected <= 1'b1;
    net_exp(8'h00, 1'b0);
    net_exp(8'h01, 1'b0);
    net_exp(8'hff, 1'b0);
    net_exp(8'hfe, 1'b1);
    host.snd(8'h5a);
    net_exp(8'h5a, 1'b1);
    $display("t_idle done");
  endtask : t_idle
  // cts_n high first ignored, then honoured once flow control is on
  task automatic t_tx();
    host.set_cts(1'b1);
    bus(8'h1c, 1'b1, 32'hc3);
    host.rcv(b);
    chk(b === 8'hc3);
    bus(8'h00, 1'b1, 32'h5);
    bus(8'h1c, 1'b1, 32'h5a);
    repeat (40) @(posedge hclk);
    chk(txd === 1'b1);
    chk(rts_n === 1'b0);
    bus(8'h18, 1'b0, 32'h0);
    chk(q[3:2] === 2'h3);
    host.set_cts(1'b0);
    host.rcv(b);
    chk(b === 8'h5a);
    $display("t_tx done");
  endtask : t_tx
  task automatic t_sync();
    net_cfg_word <= 22'h030020;
    net_cfg_valid <= 1'b1;
    @(posedge hclk);
    net_cfg_valid <= 1'b0;
    bus(8'h14, 1'b0, 32'h0);
    chk(q === 32'h00030020);
    bus(8'h00, 1'b1, 32'h0);
    net_cfg_word <= 22'h030040;
    net_cfg_valid <= 1'b1;
    @(posedge hclk);
    net_cfg_valid <= 1'b0;
    bus(8'h14, 1'b0, 32'h0);
    chk(q === 32'h00030020);
    chk(restart_req === 1'b0);
    $display("t_sync done");
  endtask : t_sync
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_drop();
    t_prebuf();
    t_idle();
    t_tx();
    t_sync();
    give_verdict();
  end
endmodule : tb_serial_to_network_packetizer
`default_nettype wire
